// ==== design/tia_pkg.sv ====
package tia_pkg;
    localparam int TEMP_W            = 12;
    localparam int VOLT_W            = 8;
    localparam int CNT_W             = 8;
    localparam int TIME_W            = 16;
    localparam int RAILS             = 2;
    localparam int EXC_TYPES         = 10;
    // equal heats limit, percent, fixed in hardware
    localparam int unsigned HEAT_LIMIT_PCT = 100;
    localparam int unsigned PCT_SCALE      = 100;
    // battery thresholds in volts
    localparam logic [VOLT_W-1:0] BATT_LOW_V  = 8'h16;
    localparam logic [VOLT_W-1:0] BATT_DEAD_V = 8'h12;
    localparam logic [CNT_W-1:0]  SHORT_AXLES = 8'h32;
    localparam logic [CNT_W-1:0]  SPIKE_MAX   = 8'h05;
    localparam logic [CNT_W-1:0]  CNT_ZERO    = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE     = 8'h01;
    localparam logic [CNT_W-1:0]  CNT_SAT     = 8'hff;
    // exception alarm bit positions
    localparam int EXC_ABS   = 0;
    localparam int EXC_SLOPE = 1;
    localparam int EXC_DIFF  = 2;
    localparam int EXC_DRAG  = 3;
    localparam int EXC_HILD  = 4;
    localparam int EXC_HOTW  = 5;
    localparam int EXC_SAT   = 6;
    localparam int EXC_WIDE  = 7;
    localparam int EXC_COLDW = 8;
    localparam int EXC_SLIDE = 9;

    typedef enum logic [1:0] {
        TIA_IDLE   = 2'b00,
        TIA_ARMED  = 2'b01,
        TIA_TRAIN  = 2'b10
    } tia_state_t;

    typedef struct packed {
        logic [TIME_W-1:0] on_time;
        logic [TIME_W-1:0] off_time;
        logic [EXC_TYPES-1:0] exc;
        logic [RAILS-1:0]     spike;
    } tia_axle_t;

    typedef struct packed {
        logic [TEMP_W-1:0] avg_rail1;
        logic [TEMP_W-1:0] avg_rail2;
        logic [VOLT_W-1:0] batt_volts;
        logic [RAILS-1:0]  cold_rail;
        logic [RAILS-1:0]  cold_wheel;
        logic [RAILS-1:0]  cold_wres;
        logic [RAILS*TEMP_W-1:0] resistor_temp;
        logic              timestamp_seen;
        logic              synthetic;
    } tia_summary_t;

    typedef struct packed {
        logic [CNT_W-1:0]  cold_trains;
        logic [CNT_W-1:0]  max_alarms;
        logic [TEMP_W-1:0] cold_journal;
    } tia_limits_t;

    typedef struct packed {
        logic             unequal_heats;
        logic             heats_consec;
        logic             low_batt;
        logic             dead_batt;
        logic             no_timestamp;
        logic             reverse_dir;
        logic             short_train;
        logic             stuck_dragger;
        logic [RAILS-1:0] cold_wheel_consec;
        logic [RAILS-1:0] cold_wres_consec;
        logic [RAILS-1:0] dead_resistor;
        logic             max_exceptions;
        logic [RAILS-1:0] spikes_exceeded;
        logic             pre_dragger;
        logic             pre_hiload;
        logic             test_train;
        logic             sliding_wheel;
    } tia_alarms_t;
endpackage

// ==== design/tia_consec.sv ====
`timescale 1ns/1ns
`default_nettype none
module tia_consec
    import tia_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             train_end,
    input  wire logic             hit,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  tripped
);
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             trip_q, trip_d;

    always_comb begin
        cnt_d  = cnt_q;
        trip_d = trip_q;
        if (train_end) begin
            if (hit) begin
                cnt_d = (cnt_q == CNT_SAT) ? cnt_q : cnt_q + CNT_ONE;
            end else begin
                cnt_d = CNT_ZERO;
            end
            // zero limit would trip on clean trains; require a hit too
            trip_d = hit && (cnt_d >= limit);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q  <= CNT_ZERO;
            trip_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            trip_q <= trip_d;
        end
    end

    assign tripped = trip_q;
endmodule // tia_consec
`default_nettype wire

// ==== design/tia_heats.sv ====
`timescale 1ns/1ns
`default_nettype none
module tia_heats
    import tia_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic [TEMP_W-1:0] avg_a,
    input  wire logic [TEMP_W-1:0] avg_b,
    output logic                   over_limit
);
    localparam int PW = TEMP_W + 8;
    logic [TEMP_W-1:0] lo, hi;
    logic [PW-1:0]     lhs, rhs;
    logic              over_q, over_d;

    // (hi-lo)/lo*100 > limit, done as a cross multiply to avoid a divider
    always_comb begin
        lo     = (avg_a < avg_b) ? avg_a : avg_b;
        hi     = (avg_a < avg_b) ? avg_b : avg_a;
        lhs    = PW'(hi - lo) * PW'(PCT_SCALE);
        rhs    = PW'(lo) * PW'(HEAT_LIMIT_PCT);
        over_d = (lhs > rhs);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            over_q <= 1'b0;
        end else begin
            over_q <= over_d;
        end
    end

    assign over_limit = over_q;
endmodule // tia_heats
`default_nettype wire

// ==== design/tia_evaluator.sv ====
// Overview of operation
// - percent difference is (high-low)/low times 100
// - unequal heats when difference exceeds fixed 100%
// - consecutive unequal-heats trains reaching limit fail
// - low battery at 18 to below 22 volts
// - dead battery below 18 volts
// - missing reader timestamp on arrival raises alarm
// - on-time above off-time on any axle after the first swaps gate sensor roles
// - swap on axle two or three flips direction
// - short train below 50 axles
// - consecutive dragger axles reaching limit is stuck
// - consecutive cold wheel trains per side alarm
// - consecutive cold wheel resistor trains per side
// - cold rail plus cold resistor means dead
// - ten per-axle alarm types count as exceptions
// - exception count above limit is integrity failure
// - more than five spikes per side fails
// - dragger open before first gate is stuck
// - high load open before first gate stuck
// - synthesised test trains carry test-train alarm
// - sliding wheel is exception and system alarm
// - cold rail when no bearing exceeds threshold
`timescale 1ns/1ns
`default_nettype none
module tia_evaluator
    import tia_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 arrival,
    input  wire logic                 gate_hit,
    input  wire logic                 first_gate_dir,
    input  wire logic                 axle_valid,
    input  wire tia_pkg::tia_axle_t   axle,
    input  wire logic                 dragger_open,
    input  wire logic                 hiload_open,
    input  wire logic                 train_end,
    input  wire tia_pkg::tia_summary_t summary,
    input  wire tia_pkg::tia_limits_t limits,
    output tia_pkg::tia_alarms_t      alarms,
    output logic                      alarms_valid,
    output logic                      first_gate_opens,
    output logic                      travel_dir
);
    import tia_pkg::*;

    tia_state_t       st_q, st_d;
    logic [CNT_W-1:0] axles_q, axles_d;
    logic [CNT_W-1:0] exc_q, exc_d;
    logic [CNT_W-1:0] drag_run_q, drag_run_d;
    logic [CNT_W-1:0] spk_q [RAILS];
    logic [CNT_W-1:0] spk_d [RAILS];
    logic             opens_q, opens_d;
    logic             dir_q, dir_d;
    logic             rev_q, rev_d;
    logic             stuck_q, stuck_d;
    logic             slide_q, slide_d;
    logic             pdrag_q, pdrag_d;
    logic             phil_q, phil_d;
    tia_alarms_t      al_q, al_d;
    logic             av_q, av_d;
    logic             unequal;
    logic             heats_trip;
    logic [RAILS-1:0] cw_trip, cwr_trip, dead_res;
    logic [3:0]       exc_n;

    tia_heats u_heats (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .avg_a      (summary.avg_rail1),
        .avg_b      (summary.avg_rail2),
        .over_limit (unequal)
    );

    // summary is held stable by the source until train_end is seen
    tia_consec u_heats_run (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .train_end (train_end),
        .hit       (unequal),
        .limit     (limits.cold_trains),
        .tripped   (heats_trip)
    );

    genvar r;
    generate
        for (r = 0; r < RAILS; r++) begin : g_rail
            tia_consec u_cw (
                .clock     (clock),
                .sys_rst   (sys_rst),
                .train_end (train_end),
                .hit       (summary.cold_wheel[r]),
                .limit     (limits.cold_trains),
                .tripped   (cw_trip[r])
            );
            tia_consec u_cwr (
                .clock     (clock),
                .sys_rst   (sys_rst),
                .train_end (train_end),
                .hit       (summary.cold_wres[r]),
                .limit     (limits.cold_trains),
                .tripped   (cwr_trip[r])
            );
            // cold rail flag already reflects the cold journal compare
            assign dead_res[r] = summary.cold_rail[r] &&
                (summary.resistor_temp[r*TEMP_W +: TEMP_W] < limits.cold_journal);
        end
    endgenerate

    always_comb begin
        exc_n = 4'h0;
        for (int i = 0; i < EXC_TYPES; i++) begin
            exc_n = exc_n + {3'h0, axle.exc[i]};
        end
    end

    always_comb begin
        st_d       = st_q;
        axles_d    = axles_q;
        exc_d      = exc_q;
        drag_run_d = drag_run_q;
        spk_d      = spk_q;
        opens_d    = opens_q;
        dir_d      = dir_q;
        rev_d      = rev_q;
        stuck_d    = stuck_q;
        slide_d    = slide_q;
        pdrag_d    = pdrag_q;
        phil_d     = phil_q;
        case (st_q)
            TIA_IDLE: begin
                if (arrival || gate_hit) begin
                    axles_d    = CNT_ZERO;
                    exc_d      = CNT_ZERO;
                    drag_run_d = CNT_ZERO;
                    for (int k = 0; k < RAILS; k++) begin
                        spk_d[k] = CNT_ZERO;
                    end
                    opens_d = 1'b1;
                    rev_d   = 1'b0;
                    stuck_d = 1'b0;
                    slide_d = 1'b0;
                    pdrag_d = 1'b0;
                    phil_d  = 1'b0;
                    dir_d   = first_gate_dir;
                    st_d    = gate_hit ? TIA_TRAIN : TIA_ARMED;
                end
            end
            TIA_ARMED: begin
                // window between arrival and first gating pulse
                if (gate_hit) begin
                    dir_d = first_gate_dir;
                    st_d  = TIA_TRAIN;
                end else begin
                    pdrag_d = pdrag_q | dragger_open;
                    phil_d  = phil_q | hiload_open;
                end
            end
            TIA_TRAIN: begin
                if (axle_valid) begin
                    axles_d = (axles_q == CNT_SAT) ? axles_q : axles_q + CNT_ONE;
                    if (axles_q != CNT_ZERO && axle.on_time > axle.off_time) begin
                        opens_d = ~opens_q;
                        rev_d  = 1'b1;
                        if (axles_q == 8'h01 || axles_q == 8'h02) begin
                            dir_d = ~dir_q;
                        end
                    end
                    exc_d = (exc_q > CNT_SAT - 8'h0a) ? CNT_SAT : exc_q + {4'h0, exc_n};
                    if (axle.exc[EXC_DRAG]) begin
                        drag_run_d = (drag_run_q == CNT_SAT) ? drag_run_q
                                                            : drag_run_q + CNT_ONE;
                        if (drag_run_d >= limits.max_alarms) begin
                            stuck_d = 1'b1;
                        end
                    end else begin
                        drag_run_d = CNT_ZERO;
                    end
                    slide_d = slide_q | axle.exc[EXC_SLIDE];
                    for (int k = 0; k < RAILS; k++) begin
                        if (axle.spike[k] && spk_q[k] != CNT_SAT) begin
                            spk_d[k] = spk_q[k] + CNT_ONE;
                        end
                    end
                end
                if (train_end) begin
                    st_d = TIA_IDLE;
                end
            end
            default: st_d = TIA_IDLE;
        endcase
    end

    // heats and cold run fields are loaded the cycle after train_end so the run counters have settled; the rest load on train_end
    always_comb begin
        al_d = al_q;
        av_d = 1'b0;
        if (train_end) begin
            al_d.low_batt = (summary.batt_volts >= BATT_DEAD_V) &&
                            (summary.batt_volts < BATT_LOW_V);
            al_d.dead_batt     = summary.batt_volts < BATT_DEAD_V;
            al_d.no_timestamp  = !summary.timestamp_seen;
            al_d.reverse_dir   = rev_q;
            al_d.short_train   = axles_q < SHORT_AXLES;
            al_d.stuck_dragger = stuck_q;
            al_d.dead_resistor = dead_res;
            al_d.max_exceptions = exc_q > limits.max_alarms;
            for (int k = 0; k < RAILS; k++) begin
                al_d.spikes_exceeded[k] = spk_q[k] > SPIKE_MAX;
            end
            al_d.pre_dragger   = pdrag_q;
            al_d.pre_hiload    = phil_q;
            al_d.test_train    = summary.synthetic;
            al_d.sliding_wheel = slide_q;
        end
        if (av_q) begin
            al_d.unequal_heats     = unequal;
            al_d.heats_consec      = heats_trip;
            al_d.cold_wheel_consec = cw_trip;
            al_d.cold_wres_consec  = cwr_trip;
        end
        av_d = train_end;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q       <= TIA_IDLE;
            axles_q    <= CNT_ZERO;
            exc_q      <= CNT_ZERO;
            drag_run_q <= CNT_ZERO;
            for (int k = 0; k < RAILS; k++) begin
                spk_q[k] <= CNT_ZERO;
            end
            // kept in output sense so the port comes straight off the flop
            opens_q <= 1'b1;
            dir_q   <= 1'b0;
            rev_q   <= 1'b0;
            stuck_q <= 1'b0;
            slide_q <= 1'b0;
            pdrag_q <= 1'b0;
            phil_q  <= 1'b0;
            al_q    <= '0;
            av_q    <= 1'b0;
        end else begin
            st_q       <= st_d;
            axles_q    <= axles_d;
            exc_q      <= exc_d;
            drag_run_q <= drag_run_d;
            spk_q      <= spk_d;
            opens_q    <= opens_d;
            dir_q      <= dir_d;
            rev_q      <= rev_d;
            stuck_q    <= stuck_d;
            slide_q    <= slide_d;
            pdrag_q    <= pdrag_d;
            phil_q     <= phil_d;
            al_q       <= al_d;
            av_q       <= av_d;
        end
    end

    logic fin_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fin_q <= 1'b0;
        end else begin
            fin_q <= av_q;
        end
    end

    assign alarms           = al_q;
    assign alarms_valid     = fin_q;
    assign first_gate_opens = opens_q;
    assign travel_dir       = dir_q;

    a_batt_dead: assert property (@(posedge clock) disable iff (sys_rst)
        train_end |=> al_q.dead_batt == ($past(summary.batt_volts) < BATT_DEAD_V))
        else $error("dead battery flag wrong");
    a_batt_low: assert property (@(posedge clock) disable iff (sys_rst)
        train_end |=> !(al_q.low_batt && al_q.dead_batt))
        else $error("low and dead battery both set");
    a_short_train: assert property (@(posedge clock) disable iff (sys_rst)
        train_end && st_q == TIA_TRAIN |=> al_q.short_train == ($past(axles_q) < SHORT_AXLES))
        else $error("short train flag wrong");
    a_gate_swap: assert property (@(posedge clock) disable iff (sys_rst)
        st_q == TIA_TRAIN && axle_valid && axles_q != CNT_ZERO
        && axle.on_time > axle.off_time |=> opens_q != $past(opens_q) && rev_q)
        else $error("gate roles not swapped");
    a_dir_flip: assert property (@(posedge clock) disable iff (sys_rst)
        st_q == TIA_TRAIN && axle_valid && axles_q == 8'h01
        && axle.on_time > axle.off_time |=> dir_q != $past(dir_q))
        else $error("direction not reversed");
    a_no_stamp: assert property (@(posedge clock) disable iff (sys_rst)
        train_end && !summary.timestamp_seen |=> al_q.no_timestamp ##1 alarms_valid)
        else $error("missing timestamp not flagged");
    a_pre_drag: assert property (@(posedge clock) disable iff (sys_rst)
        st_q == TIA_ARMED && !gate_hit && dragger_open |=> pdrag_q)
        else $error("pretrain dragger missed");
    a_test_train: assert property (@(posedge clock) disable iff (sys_rst)
        train_end |=> al_q.test_train == $past(summary.synthetic))
        else $error("test train flag wrong");
    a_spikes: assert property (@(posedge clock) disable iff (sys_rst)
        train_end |=> al_q.spikes_exceeded[0] == ($past(spk_q[0]) > SPIKE_MAX))
        else $error("spike limit wrong");

    c_full_train: cover property (@(posedge clock) st_q == TIA_ARMED ##[1:50] st_q == TIA_TRAIN);
    c_reverse: cover property (@(posedge clock) alarms_valid && alarms.reverse_dir);
    c_short: cover property (@(posedge clock) alarms_valid && alarms.short_train);
endmodule // tia_evaluator
`default_nettype wire

// ==== test/tia_track_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tia_track_model
    import tia_pkg::*;
(
    input  wire logic          clock,
    output logic               arrival,
    output logic               gate_hit,
    output logic               axle_valid,
    output tia_pkg::tia_axle_t axle,
    output logic               dragger_open,
    output logic               hiload_open,
    output logic               train_end
);
    // per-axle script, written by the bench before each train
    logic [EXC_TYPES-1:0] exc_at [64];
    logic [RAILS-1:0]     spk_at [64];
    logic                 swp_at [64];

    task automatic clear();
        for (int i = 0; i < 64; i++) begin
            exc_at[i] = '0;
            spk_at[i] = '0;
            swp_at[i] = 1'b0;
        end
    endtask

    initial begin
        {arrival, gate_hit, axle_valid, dragger_open, hiload_open, train_end} = '0;
        axle = '0;
        clear();
    end

    // arrival, one pretrain cycle, first gate, n axles back to back, departure
    task automatic run(input int n, input logic pd, input logic ph);
        @(negedge clock) arrival = 1'b1;
        @(negedge clock) arrival = 1'b0;
        dragger_open = pd;
        hiload_open = ph;
        @(negedge clock) gate_hit = 1'b1;
        dragger_open = 1'b0;
        hiload_open = 1'b0;
        @(negedge clock) gate_hit = 1'b0;
        for (int i = 0; i < n; i++) begin
            axle_valid = 1'b1;
            axle.on_time = swp_at[i] ? 16'h001e : 16'h000a;
            axle.off_time = 16'h0014;
            axle.exc = exc_at[i];
            axle.spike = spk_at[i];
            @(negedge clock);
        end
        axle_valid = 1'b0;
        // released lines must not look like a stale axle
        axle = ~axle;
        train_end = 1'b1;
        @(negedge clock) train_end = 1'b0;
        clear();
    endtask
endmodule // tia_track_model
`default_nettype wire

// ==== test/tb_train_integrity_alarm_evaluator.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_train_integrity_alarm_evaluator;
    import tia_pkg::*;
    logic         clock, sys_rst, arrival, gate_hit, first_gate_dir, axle_valid;
    logic         dragger_open, hiload_open, train_end;
    logic         alarms_valid, first_gate_opens, travel_dir;
    tia_axle_t    axle;
    tia_summary_t summary;
    tia_limits_t  limits;
    tia_alarms_t  alarms, exp_al;
    int           n_errors = 0;
    int           checked = 0;

    tia_evaluator dut (.clock(clock), .sys_rst(sys_rst), .arrival(arrival),
        .gate_hit(gate_hit), .first_gate_dir(first_gate_dir), .axle_valid(axle_valid),
        .axle(axle), .dragger_open(dragger_open), .hiload_open(hiload_open),
        .train_end(train_end), .summary(summary), .limits(limits), .alarms(alarms),
        .alarms_valid(alarms_valid), .first_gate_opens(first_gate_opens),
        .travel_dir(travel_dir));

    tia_track_model trk (.clock(clock), .arrival(arrival), .gate_hit(gate_hit),
        .axle_valid(axle_valid), .axle(axle), .dragger_open(dragger_open),
        .hiload_open(hiload_open), .train_end(train_end));

    task automatic conclude();
        $display("compares %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // healthy train: equal heats, 24 volts, timestamp seen
    task automatic base();
        summary = '0;
        summary.avg_rail1 = 12'h064;
        summary.avg_rail2 = 12'h064;
        summary.batt_volts = 8'h18;
        summary.resistor_temp = {12'h100, 12'h100};
        summary.timestamp_seen = 1'b1;
        exp_al = '0;
    endtask

    task automatic go(input int n, input logic pd, input logic ph);
        int k;
        trk.run(n, pd, ph);
        k = 0;
        while (alarms_valid !== 1'b1) begin
            @(posedge clock);
            #1;
            k++;
            if (k > 8) begin
                n_errors++;
                $display("Error alarms_valid expected 1 seen timeout");
                conclude();
            end
        end
        // run returns past the train_end edge, so one edge of the two remains
        `CHK("valid latency", 1, k)
        `CHK("alarms", exp_al, alarms)
        @(negedge clock);
    endtask

    task automatic t_basic();
        base();
        `CHK("idle alarms", exp_al, alarms)
        `CHK("idle gate roles", 1'b1, first_gate_opens)
        go(50, 1'b0, 1'b0);
        exp_al.short_train = 1'b1;
        go(49, 1'b0, 1'b0);
        base();
        summary.timestamp_seen = 1'b0;
        summary.synthetic = 1'b1;
        exp_al.no_timestamp = 1'b1;
        exp_al.test_train = 1'b1;
        go(50, 1'b0, 1'b0);
        $display("test basic done");
    endtask

    task automatic t_batt();
        logic [7:0] v [4] = '{8'h11, 8'h12, 8'h15, 8'h16};
        for (int i = 0; i < 4; i++) begin
            base();
            summary.batt_volts = v[i];
            exp_al.dead_batt = (i == 0);
            exp_al.low_batt = (i == 1 || i == 2);
            go(50, 1'b0, 1'b0);
        end
        $display("test battery done");
    endtask

    // 100 against 200 sits exactly on the limit, so it must stay quiet
    task automatic t_heats();
        base();
        summary.avg_rail2 = 12'h0c8;
        go(50, 1'b0, 1'b0);
        base();
        summary.avg_rail1 = 12'h0fa;
        exp_al.unequal_heats = 1'b1;
        go(50, 1'b0, 1'b0);
        base();
        summary.avg_rail2 = 12'h0fa;
        exp_al.unequal_heats = 1'b1;
        exp_al.heats_consec = 1'b1;
        go(50, 1'b0, 1'b0);
        base();
        go(50, 1'b0, 1'b0);
        // after the clean train one more failure must restart the count at one
        base();
        summary.avg_rail1 = 12'h0fa;
        exp_al.unequal_heats = 1'b1;
        go(50, 1'b0, 1'b0);
        $display("test heats done");
    endtask

    task automatic t_cold();
        for (int i = 0; i < 5; i++) begin
            base();
            if (i == 0 || i == 1 || i == 3) begin
                summary.cold_wheel = 2'b01;
                summary.cold_wres = 2'b10;
            end
            exp_al.cold_wheel_consec = (i == 1) ? 2'b01 : 2'b00;
            exp_al.cold_wres_consec = (i == 1) ? 2'b10 : 2'b00;
            go(50, 1'b0, 1'b0);
        end
        base();
        summary.cold_rail = 2'b11;
        summary.resistor_temp = {12'h050, 12'h04f};
        exp_al.dead_resistor = 2'b01;
        go(50, 1'b0, 1'b0);
        $display("test cold done");
    endtask

    task automatic t_exc();
        base();
        for (int i = 0; i < 9; i++) trk.exc_at[i] = 10'h001 << i;
        go(50, 1'b0, 1'b0);
        for (int i = 0; i < 10; i++) trk.exc_at[i] = 10'h001 << i;
        exp_al.max_exceptions = 1'b1;
        exp_al.sliding_wheel = 1'b1;
        go(50, 1'b0, 1'b0);
        base();
        for (int i = 0; i < 9; i++) trk.exc_at[i + 5] = 10'h008;
        exp_al.stuck_dragger = 1'b1;
        go(50, 1'b0, 1'b0);
        base();
        // two runs of eight split by one clean axle
        for (int i = 0; i < 16; i++) trk.exc_at[i + i / 8] = 10'h008;
        exp_al.max_exceptions = 1'b1;
        go(50, 1'b0, 1'b0);
        base();
        for (int i = 0; i < 6; i++) trk.spk_at[i] = (i < 5) ? 2'b11 : 2'b10;
        exp_al.spikes_exceeded = 2'b10;
        go(50, 1'b0, 1'b0);
        $display("test exceptions done");
    endtask

    task automatic t_pre_rev();
        base();
        exp_al.pre_dragger = 1'b1;
        go(50, 1'b1, 1'b0);
        base();
        exp_al.pre_hiload = 1'b1;
        go(50, 1'b0, 1'b1);
        base();
        trk.swp_at[4] = 1'b1;
        exp_al.reverse_dir = 1'b1;
        go(50, 1'b0, 1'b0);
        `CHK("gate roles", 1'b0, first_gate_opens)
        `CHK("late swap direction", 1'b1, travel_dir)
        trk.swp_at[1] = 1'b1;
        go(50, 1'b0, 1'b0);
        `CHK("early swap direction", 1'b0, travel_dir)
        // third axle swap, latched direction low this time
        first_gate_dir = 1'b0;
        trk.swp_at[2] = 1'b1;
        go(50, 1'b0, 1'b0);
        `CHK("third axle direction", 1'b1, travel_dir)
        `CHK("third axle gate roles", 1'b0, first_gate_opens)
        first_gate_dir = 1'b1;
        $display("test pretrain and reverse done");
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        sys_rst = 1'b1;
        first_gate_dir = 1'b1;
        // cold trains 2, max alarms 9, cold journal 0x50
        limits = {8'h02, 8'h09, 12'h050};
        base();
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        t_basic();
        t_batt();
        t_heats();
        t_cold();
        t_exc();
        t_pre_rev();
        conclude();
    end
endmodule // tb_train_integrity_alarm_evaluator
`default_nettype wire
